// *** hw/timer_compare_capture_regs.svh ***
`ifndef TIMER_COMPARE_CAPTURE_REGS_SVH
`define TIMER_COMPARE_CAPTURE_REGS_SVH

// ============================================================
// register indices (byte address = 4 * index)
`define IDX_CONFIG_ONE 16'ha050
`define IDX_CONFIG_TWO 16'ha051
`define IDX_CONFIG_THREE 16'ha052
`define IDX_PERIOD_LOW 16'ha054
`define IDX_PERIOD_HIGH 16'ha055
`define IDX_COMPARE_LOW 16'ha056
`define IDX_COMPARE_HIGH 16'ha057
`define IDX_CAPT_RISE_LOW 16'ha060
`define IDX_CAPT_RISE_HIGH 16'ha061
`define IDX_CAPT_FALL_LOW 16'ha062
`define IDX_CAPT_FALL_HIGH 16'ha063

// ============================================================
// config one field positions
`define C1_ENABLE_BIT 7
`define C1_SCALE_MSB 6
`define C1_SCALE_LSB 4
`define C1_SELECT_MSB 3
`define C1_SELECT_LSB 2
`define C1_WRAP_SEL_BIT 1
`define C1_RUN_BIT 0

// ============================================================
// config two field positions
`define C2_CLEAR_BIT 7
`define C2_WRAP_POL_BIT 3
`define C2_MATCH_POL_BIT 2
`define C2_WRAP_FLAG_BIT 1
`define C2_MATCH_FLAG_BIT 0

// ============================================================
// config three field positions
`define C3_WRAP_IRQ_BIT 7
`define C3_MATCH_IRQ_BIT 6
`define C3_ENCODER_BIT 5
`define C3_CLR_AFTER_BIT 4
`define C3_RISE_EN_BIT 3
`define C3_FALL_EN_BIT 2
`define C3_SOFT_RISE_BIT 1
`define C3_SOFT_FALL_BIT 0

// ============================================================
// match output modes, pulse widths in counting clocks, reset value
`define MODE_PULSE_SHORT 2'h0
`define MODE_PULSE_LONG 2'h1
`define MODE_PWM_LEVEL 2'h2
`define MODE_TOGGLE 2'h3
`define PULSE_SHORT_TICKS 7'h10
`define PULSE_LONG_TICKS 7'h40
`define RESET_BYTE 8'h00

// ============================================================
// axi responses
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// *** hw/timer_compare_capture_pkg.sv ***
package timer_compare_capture_pkg;

    // ============================================================
    // software control fields
    typedef struct packed {
        logic timer_enable;
        logic [2:0] count_clock_scale;
        logic [1:0] match_output_select;
        logic wrap_pulse_select;
        logic run;
        logic wrap_output_polarity;
        logic match_output_polarity;
        logic wrap_irq_enable;
        logic match_irq_enable;
        logic encoder_capture_enable;
        logic clear_after_capture;
        logic rise_capture_enable;
        logic fall_capture_enable;
    } ctrl_type;

    // ============================================================
    // synchronised encoder pin levels
    typedef struct packed {
        logic index_level;
        logic phase_a_level;
        logic phase_b_level;
    } encoder_pins_type;

endpackage : timer_compare_capture_pkg

// *** hw/timer_compare_capture.sv ***
`timescale 1ns/10ps
`include "timer_compare_capture_regs.svh"

module timer_compare_capture #(
    parameter int ADDR_W = 18
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic external_capture_input_i,
    input wire logic encoder_phase_a_i,
    input wire logic encoder_phase_b_i,
    input wire logic encoder_index_i,
    input wire logic quadrature_unit_event_i,
    output logic wrap_event_o,
    output logic match_event_o,
    output logic irq_o
);
    import timer_compare_capture_pkg::*;

    // ============================================================
    // helpers
    function automatic logic [6:0] scale_mask(input logic [2:0] scale);
        logic [7:0] m;
        m = (8'h01 << scale) - 8'h01;
        return m[6:0];
    endfunction : scale_mask

    function automatic logic is_mapped(input logic [15:0] idx);
        return (idx == `IDX_CONFIG_ONE) || (idx == `IDX_CONFIG_TWO)
            || (idx == `IDX_CONFIG_THREE) || (idx == `IDX_PERIOD_LOW)
            || (idx == `IDX_PERIOD_HIGH) || (idx == `IDX_COMPARE_LOW)
            || (idx == `IDX_COMPARE_HIGH) || (idx == `IDX_CAPT_RISE_LOW)
            || (idx == `IDX_CAPT_RISE_HIGH) || (idx == `IDX_CAPT_FALL_LOW)
            || (idx == `IDX_CAPT_FALL_HIGH);
    endfunction : is_mapped

    // ============================================================
    // state
    ctrl_type ctrl_ff;
    encoder_pins_type pins_meta_ff;
    encoder_pins_type pins_ff;
    logic capt_meta_ff;
    logic capt_sync_ff;
    logic capt_prev_ff;
    logic [6:0] pre_ff;
    logic [15:0] count_ff;
    logic [15:0] period_staged_ff;
    logic [15:0] period_active_ff;
    logic [15:0] compare_staged_ff;
    logic [15:0] compare_active_ff;
    logic [7:0] period_hold_ff;
    logic [7:0] compare_hold_ff;
    logic [15:0] capture_rise_value_ff;
    logic [15:0] capture_fall_value_ff;
    logic [6:0] wrap_pulse_ff;
    logic [6:0] match_pulse_ff;
    logic toggle_ff;
    logic wrap_flag_ff;
    logic match_flag_ff;
    logic aw_held_ff;
    logic w_held_ff;
    logic [ADDR_W-1:0] aw_addr_ff;
    logic [7:0] w_byte_ff;
    logic w_lane_ff;

    // ============================================================
    // axi write side
    wire aw_take = s_axi_awvalid_i & s_axi_awready_o;
    wire w_take = s_axi_wvalid_i & s_axi_wready_o;
    wire do_write = ce_i & aw_held_ff & w_held_ff & ~s_axi_bvalid_o;
    wire [15:0] wr_idx = aw_addr_ff[17:2];
    wire wr_hit = is_mapped(wr_idx) & (aw_addr_ff[1:0] == 2'h0);
    wire wr_byte = do_write & wr_hit & w_lane_ff;
    wire [7:0] wd = w_byte_ff;
    wire wr_cfg1 = wr_byte & (wr_idx == `IDX_CONFIG_ONE);
    wire wr_cfg2 = wr_byte & (wr_idx == `IDX_CONFIG_TWO);
    wire wr_cfg3 = wr_byte & (wr_idx == `IDX_CONFIG_THREE);
    wire wr_prd_lo = wr_byte & (wr_idx == `IDX_PERIOD_LOW);
    wire wr_prd_hi = wr_byte & (wr_idx == `IDX_PERIOD_HIGH);
    wire wr_cmp_lo = wr_byte & (wr_idx == `IDX_COMPARE_LOW);
    wire wr_cmp_hi = wr_byte & (wr_idx == `IDX_COMPARE_HIGH);

    assign s_axi_awready_o = ce_i & ~aw_held_ff & ~s_axi_bvalid_o;
    assign s_axi_wready_o = ce_i & ~w_held_ff & ~s_axi_bvalid_o;
    assign s_axi_arready_o = ce_i & ~s_axi_rvalid_o;

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            aw_addr_ff <= '0;
            w_byte_ff <= `RESET_BYTE;
            w_lane_ff <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `RESP_OKAY;
        end
        else if (ce_i)
        begin
            if (aw_take)
            begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr_i;
            end
            if (w_take)
            begin
                w_held_ff <= 1'b1;
                w_byte_ff <= s_axi_wdata_i[7:0];
                w_lane_ff <= s_axi_wstrb_i[0];
            end
            if (do_write)
            begin
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= wr_hit ? `RESP_OKAY : `RESP_DECERR;
            end
            else if (s_axi_bready_i)
            begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    // ============================================================
    // pin synchronisers and edge detect
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            pins_meta_ff <= '0;
            pins_ff <= '0;
            capt_meta_ff <= 1'b0;
            capt_sync_ff <= 1'b0;
            capt_prev_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            pins_meta_ff <= {encoder_index_i, encoder_phase_a_i, encoder_phase_b_i};
            pins_ff <= pins_meta_ff;
            capt_meta_ff <= external_capture_input_i;
            capt_sync_ff <= capt_meta_ff;
            capt_prev_ff <= capt_sync_ff;
        end
    end

    // ============================================================
    // counting and capture decode
    wire timer_clear = wr_cfg2 & wd[`C2_CLEAR_BIT];
    wire counting_status = ctrl_ff.timer_enable & ctrl_ff.run;
    wire [6:0] mask = scale_mask(ctrl_ff.count_clock_scale);
    wire tick = counting_status & ((pre_ff & mask) == mask);
    wire at_period = (count_ff == period_active_ff);
    wire wrap_hit = tick & at_period;
    wire match_hit = tick & (count_ff == compare_active_ff);
    wire soft_rise = wr_cfg3 & wd[`C3_SOFT_RISE_BIT];
    wire soft_fall = wr_cfg3 & wd[`C3_SOFT_FALL_BIT];
    wire ext_rise = ctrl_ff.rise_capture_enable & capt_sync_ff & ~capt_prev_ff;
    wire ext_fall = ctrl_ff.fall_capture_enable & ~capt_sync_ff & capt_prev_ff;
    wire enc_capt = ctrl_ff.encoder_capture_enable & quadrature_unit_event_i;
    // any source may fire in the same cycle as another
    wire capt_rise = ext_rise | enc_capt | soft_rise;
    wire capt_fall = ext_fall | soft_fall;
    wire capt_any = capt_rise | capt_fall;
    wire zero_all = ~ctrl_ff.timer_enable | timer_clear;

    // ============================================================
    // control register fields
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            ctrl_ff <= '0;
        end
        else if (ce_i)
        begin
            if (wr_cfg1)
            begin
                ctrl_ff.timer_enable <= wd[`C1_ENABLE_BIT];
                ctrl_ff.count_clock_scale <= wd[`C1_SCALE_MSB:`C1_SCALE_LSB];
                ctrl_ff.match_output_select <= wd[`C1_SELECT_MSB:`C1_SELECT_LSB];
                ctrl_ff.wrap_pulse_select <= wd[`C1_WRAP_SEL_BIT];
                ctrl_ff.run <= wd[`C1_RUN_BIT];
            end
            if (wr_cfg2)
            begin
                ctrl_ff.wrap_output_polarity <= wd[`C2_WRAP_POL_BIT];
                ctrl_ff.match_output_polarity <= wd[`C2_MATCH_POL_BIT];
            end
            if (timer_clear)
            begin
                ctrl_ff.run <= 1'b0;
            end
            if (wr_cfg3)
            begin
                ctrl_ff.wrap_irq_enable <= wd[`C3_WRAP_IRQ_BIT];
                ctrl_ff.match_irq_enable <= wd[`C3_MATCH_IRQ_BIT];
                ctrl_ff.encoder_capture_enable <= wd[`C3_ENCODER_BIT];
                ctrl_ff.clear_after_capture <= wd[`C3_CLR_AFTER_BIT];
                ctrl_ff.rise_capture_enable <= wd[`C3_RISE_EN_BIT];
                ctrl_ff.fall_capture_enable <= wd[`C3_FALL_EN_BIT];
            end
        end
    end

    // ============================================================
    // period and compare shadows
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            period_hold_ff <= `RESET_BYTE;
            compare_hold_ff <= `RESET_BYTE;
            period_staged_ff <= '0;
            compare_staged_ff <= '0;
            period_active_ff <= '0;
            compare_active_ff <= '0;
        end
        else if (ce_i)
        begin
            if (wr_prd_hi)
            begin
                period_hold_ff <= wd;
            end
            if (wr_prd_lo)
            begin
                period_staged_ff <= {period_hold_ff, wd};
            end
            if (wr_cmp_hi)
            begin
                compare_hold_ff <= wd;
            end
            if (wr_cmp_lo)
            begin
                compare_staged_ff <= {compare_hold_ff, wd};
            end
            // a stopped-by-disable timer has no period in progress
            if (wrap_hit | zero_all)
            begin
                period_active_ff <= period_staged_ff;
                compare_active_ff <= compare_staged_ff;
            end
        end
    end

    // ============================================================
    // prescaler, counter, captures
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            pre_ff <= '0;
            count_ff <= '0;
            capture_rise_value_ff <= '0;
            capture_fall_value_ff <= '0;
        end
        else if (ce_i)
        begin
            pre_ff <= counting_status ? pre_ff + 7'h01 : 7'h00;
            if (zero_all)
            begin
                count_ff <= '0;
                capture_rise_value_ff <= '0;
                capture_fall_value_ff <= '0;
            end
            else
            begin
                if (capt_any & ctrl_ff.clear_after_capture)
                begin
                    count_ff <= '0;
                end
                else if (tick)
                begin
                    count_ff <= at_period ? 16'h0000 : count_ff + 16'h0001;
                end
                if (capt_rise)
                begin
                    capture_rise_value_ff <= count_ff;
                end
                if (capt_fall)
                begin
                    capture_fall_value_ff <= count_ff;
                end
            end
        end
    end

    // ============================================================
    // output waveforms
    wire [6:0] wrap_width = ctrl_ff.wrap_pulse_select ? `PULSE_LONG_TICKS : `PULSE_SHORT_TICKS;
    wire [6:0] match_width = (ctrl_ff.match_output_select == `MODE_PULSE_LONG)
        ? `PULSE_LONG_TICKS : `PULSE_SHORT_TICKS;
    wire pulse_mode = ~ctrl_ff.match_output_select[1];
    logic match_raw;
    always_comb
    begin
        case (ctrl_ff.match_output_select)
            `MODE_PWM_LEVEL: match_raw = (count_ff >= compare_active_ff);
            `MODE_TOGGLE: match_raw = toggle_ff;
            default: match_raw = (match_pulse_ff != 7'h00);
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            wrap_pulse_ff <= '0;
            match_pulse_ff <= '0;
            toggle_ff <= 1'b0;
            wrap_event_o <= 1'b0;
            match_event_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (zero_all)
            begin
                wrap_pulse_ff <= '0;
                match_pulse_ff <= '0;
                toggle_ff <= 1'b0;
            end
            else
            begin
                if (wrap_hit)
                begin
                    wrap_pulse_ff <= wrap_width;
                end
                else if (tick && wrap_pulse_ff != 7'h00)
                begin
                    wrap_pulse_ff <= wrap_pulse_ff - 7'h01;
                end
                if (match_hit & pulse_mode)
                begin
                    match_pulse_ff <= match_width;
                end
                else if (tick && match_pulse_ff != 7'h00)
                begin
                    match_pulse_ff <= match_pulse_ff - 7'h01;
                end
                if (match_hit && ctrl_ff.match_output_select == `MODE_TOGGLE)
                begin
                    toggle_ff <= ~toggle_ff;
                end
            end
            // disabled forces low regardless of polarity
            wrap_event_o <= ctrl_ff.timer_enable
                & ((wrap_pulse_ff != 7'h00) ^ ctrl_ff.wrap_output_polarity);
            match_event_o <= ctrl_ff.timer_enable
                & (match_raw ^ ctrl_ff.match_output_polarity);
        end
    end

    // ============================================================
    // sticky flags and interrupt
    wire wrap_flag_clr = wr_cfg2 & ~wd[`C2_WRAP_FLAG_BIT];
    wire match_flag_clr = wr_cfg2 & ~wd[`C2_MATCH_FLAG_BIT];

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            wrap_flag_ff <= 1'b0;
            match_flag_ff <= 1'b0;
            irq_o <= 1'b0;
        end
        else if (ce_i)
        begin
            // set beats a clear landing in the same cycle
            wrap_flag_ff <= wrap_hit | (wrap_flag_ff & ~wrap_flag_clr);
            match_flag_ff <= match_hit | (match_flag_ff & ~match_flag_clr);
            irq_o <= (wrap_flag_ff & ctrl_ff.wrap_irq_enable)
                | (match_flag_ff & ctrl_ff.match_irq_enable);
        end
    end

    // ============================================================
    // read side
    wire [15:0] rd_idx = s_axi_araddr_i[17:2];
    wire rd_hit = is_mapped(rd_idx) & (s_axi_araddr_i[1:0] == 2'h0);
    logic [7:0] rd_byte;
    always_comb
    begin
        case (rd_idx)
            `IDX_CONFIG_ONE: rd_byte = {ctrl_ff.timer_enable, ctrl_ff.count_clock_scale,
                ctrl_ff.match_output_select, ctrl_ff.wrap_pulse_select,
                counting_status};
            `IDX_CONFIG_TWO: rd_byte = {1'b0, pins_ff, ctrl_ff.wrap_output_polarity,
                ctrl_ff.match_output_polarity, wrap_flag_ff, match_flag_ff};
            `IDX_CONFIG_THREE: rd_byte = {ctrl_ff.wrap_irq_enable, ctrl_ff.match_irq_enable,
                ctrl_ff.encoder_capture_enable, ctrl_ff.clear_after_capture,
                ctrl_ff.rise_capture_enable, ctrl_ff.fall_capture_enable, 2'h0};
            `IDX_PERIOD_LOW: rd_byte = count_ff[7:0];
            `IDX_PERIOD_HIGH: rd_byte = count_ff[15:8];
            `IDX_COMPARE_LOW: rd_byte = compare_staged_ff[7:0];
            `IDX_COMPARE_HIGH: rd_byte = compare_staged_ff[15:8];
            `IDX_CAPT_RISE_LOW: rd_byte = capture_rise_value_ff[7:0];
            `IDX_CAPT_RISE_HIGH: rd_byte = capture_rise_value_ff[15:8];
            `IDX_CAPT_FALL_LOW: rd_byte = capture_fall_value_ff[7:0];
            `IDX_CAPT_FALL_HIGH: rd_byte = capture_fall_value_ff[15:8];
            default: rd_byte = `RESET_BYTE;
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= '0;
            s_axi_rresp_o <= `RESP_OKAY;
        end
        else if (ce_i)
        begin
            if (s_axi_arvalid_i & s_axi_arready_o)
            begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o <= rd_hit ? {24'h000000, rd_byte} : 32'h00000000;
                s_axi_rresp_o <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
            end
            else if (s_axi_rready_i)
            begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end

endmodule : timer_compare_capture

// *** test/timer_compare_capture_properties.sv ***
`timescale 1ns/10ps
// ============================================================
// port checker
module timer_compare_capture_properties (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic wrap_event_o,
    input wire logic match_event_o,
    input wire logic irq_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // reset itself is the cause here, so it must not disable the check
    property p_reset_quiet;
        disable iff (1'h0) rst_i |=> !wrap_event_o && !match_event_o && !irq_o;
    endproperty
    property p_write_answer;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o;
    endproperty
    property p_resp_once;
        s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o;
    endproperty
    property p_read_answer;
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
    endproperty
    property p_read_once;
        s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o;
    endproperty
    property p_byte_wide;
        s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0;
    endproperty
    property p_one_read;
        s_axi_rvalid_o |-> !s_axi_arready_o;
    endproperty
    property p_no_accept;
        s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
    a_write_answer: assert property (p_write_answer) else $error("no write response");
    a_resp_once: assert property (p_resp_once) else $error("write response repeated");
    a_read_answer: assert property (p_read_answer) else $error("no read data");
    a_read_once: assert property (p_read_once) else $error("read data repeated");
    a_byte_wide: assert property (p_byte_wide) else $error("read data above byte");
    a_one_read: assert property (p_one_read) else $error("read taken while busy");
    a_no_accept: assert property (p_no_accept) else $error("write taken while busy");
    c_write: cover property (s_axi_bvalid_o && s_axi_bready_i);
    c_wrap: cover property ($rose(wrap_event_o));
    c_match: cover property ($rose(match_event_o));
endmodule : timer_compare_capture_properties

// *** test/capture_source_model.sv ***
`timescale 1ns/10ps
// ============================================================
// capture pin and encoder event source
module capture_source_model (
    input wire logic ref_clk_i,
    input wire logic rise_req_i,
    output logic capture_pin_o,
    output logic encoder_event_o
);
    logic [2:0] hold_ff = 3'h0;
    logic event_ff = 1'h0;
    wire start = rise_req_i && hold_ff == 3'h0;
    always_ff @(posedge ref_clk_i)
    begin
        event_ff <= start;
        hold_ff <= start ? 3'h7 : hold_ff - {2'h0, hold_ff != 3'h0};
    end
    // pin high for seven cycles gives one rising and one falling edge
    assign capture_pin_o = hold_ff != 3'h0;
    assign encoder_event_o = event_ff;
endmodule : capture_source_model

// *** test/timer_compare_capture_bench.sv ***
`timescale 1ns/10ps
`include "timer_compare_capture_regs.svh"
// ============================================================
// bench top
module timer_compare_capture_bench;
    import timer_compare_capture_pkg::*;
    logic ref_clk_i;
    logic rst_i = 1'h1, ce_i = 1'h1, rise_req = 1'h0;
    logic [17:0] s_axi_awaddr_i = 18'h0, s_axi_araddr_i = 18'h0;
    logic [31:0] s_axi_wdata_i = 32'h0;
    logic [3:0] s_axi_wstrb_i = 4'hf;
    logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_arvalid_i = 1'h0;
    // responses are always accepted at once
    logic s_axi_bready_i = 1'h1, s_axi_rready_i = 1'h1;
    logic encoder_phase_a_i = 1'h0, encoder_phase_b_i = 1'h0, encoder_index_i = 1'h0;
    logic external_capture_input_i, quadrature_unit_event_i;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic [31:0] s_axi_rdata_o;
    logic wrap_event_o, match_event_o, irq_o;
    logic [33:0] exp_q[$];
    logic [7:0] pins;
    logic [15:0] regs [11] = '{`IDX_CONFIG_ONE, `IDX_CONFIG_TWO, `IDX_CONFIG_THREE,
        `IDX_PERIOD_LOW, `IDX_PERIOD_HIGH, `IDX_COMPARE_LOW, `IDX_COMPARE_HIGH,
        `IDX_CAPT_RISE_LOW, `IDX_CAPT_RISE_HIGH, `IDX_CAPT_FALL_LOW, `IDX_CAPT_FALL_HIGH};
    int fail_count = 0, n_compared = 0, cycles = 0;
    timer_compare_capture u_timer_compare_capture (.*);
    capture_source_model u_capture_source_model (.ref_clk_i(ref_clk_i), .rise_req_i(rise_req),
        .capture_pin_o(external_capture_input_i), .encoder_event_o(quadrature_unit_event_i));
    task automatic check(input string what, input logic [33:0] seen, input logic [33:0] want);
        n_compared++;
        if (seen !== want)
        begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, want, seen);
        end
    endtask : check
    task automatic conclude;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude
    // one register access; its expected response goes to the monitor
    task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] d,
        input logic [33:0] e);
        exp_q.push_back(e);
        s_axi_awaddr_i <= {idx, 2'h0};
        s_axi_araddr_i <= {idx, 2'h0};
        s_axi_wdata_i <= {24'h0, d};
        s_axi_awvalid_i <= wr;
        s_axi_wvalid_i <= wr;
        s_axi_arvalid_i <= !wr;
        do
        begin
            @(posedge ref_clk_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'h0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'h0;
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'h0;
        end
        while (!(wr ? s_axi_bvalid_o : s_axi_rvalid_o));
    endtask : xfer
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : idle
    initial
    begin
        ref_clk_i = 1'h0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    // ============================================================
    // monitor and timeout
    always @(posedge ref_clk_i)
    begin
        cycles++;
        if (s_axi_bvalid_o) check("write response", {s_axi_bresp_o, 32'h0}, exp_q.pop_front());
        if (s_axi_rvalid_o) check("read data", {s_axi_rresp_o, s_axi_rdata_o}, exp_q.pop_front());
        if (cycles == 6000)
        begin
            fail_count++;
            conclude();
        end
    end
    // ============================================================
    // scenarios
    initial
    begin
        void'($urandom(32'h7960));
        idle(3);
        rst_i <= 1'h0;
        {encoder_index_i, encoder_phase_a_i, encoder_phase_b_i} <= 3'($urandom);
        idle(5);
        pins = {1'h0, encoder_index_i, encoder_phase_a_i, encoder_phase_b_i, 4'h0};
        foreach (regs[i]) xfer(0, regs[i], 0, {26'h0, regs[i] == `IDX_CONFIG_TWO ? pins : 8'h0});
        xfer(0, 16'ha000, 0, {2'h3, 32'h0});
        xfer(1, `IDX_COMPARE_HIGH, 8'h00, 0);
        xfer(1, `IDX_COMPARE_LOW, 8'h02, 0);
        xfer(1, `IDX_PERIOD_HIGH, 8'h00, 0);
        xfer(1, `IDX_PERIOD_LOW, 8'h30, 0);
        xfer(0, `IDX_COMPARE_LOW, 0, 34'h02);
        xfer(1, `IDX_CONFIG_THREE, 8'hc0, 0);
        xfer(1, `IDX_CONFIG_ONE, 8'h81, 0);
        xfer(0, `IDX_CONFIG_ONE, 0, 34'h81);
        idle(80);
        xfer(1, `IDX_CONFIG_ONE, 8'h80, 0);
        xfer(0, `IDX_CONFIG_ONE, 0, 34'h80);
        xfer(0, `IDX_CONFIG_TWO, 0, {26'h0, pins | 8'h03});
        check("interrupt", {33'h0, irq_o}, 34'h1);
        xfer(1, `IDX_CONFIG_TWO, 8'h0c, 0);
        xfer(0, `IDX_CONFIG_TWO, 0, {26'h0, pins | 8'h0c});
        idle(3);
        check("wrap output", {33'h0, wrap_event_o}, 34'h1);
        check("match output", {33'h0, match_event_o}, 34'h1);
        check("cleared interrupt", {33'h0, irq_o}, 34'h0);
        xfer(1, `IDX_CONFIG_TWO, 8'h00, 0);
        xfer(1, `IDX_CONFIG_THREE, 8'h18, 0);
        rise_req <= 1'h1;
        idle(1);
        rise_req <= 1'h0;
        idle(12);
        xfer(0, `IDX_PERIOD_LOW, 0, 0);
        xfer(0, `IDX_CAPT_RISE_LOW, 0, 34'h24);
        xfer(0, `IDX_CAPT_FALL_LOW, 0, 34'h00);
        xfer(1, `IDX_CONFIG_THREE, 8'h1a, 0);
        xfer(0, `IDX_CONFIG_THREE, 0, 34'h18);
        xfer(1, `IDX_CONFIG_ONE, 8'h08, 0);
        xfer(1, `IDX_COMPARE_HIGH, 8'h00, 0);
        xfer(1, `IDX_COMPARE_LOW, 8'h00, 0);
        xfer(1, `IDX_CONFIG_ONE, 8'h88, 0);
        idle(3);
        check("match level", {33'h0, match_event_o}, 34'h1);
        xfer(1, `IDX_CONFIG_ONE, 8'h89, 0);
        idle(20);
        xfer(1, `IDX_CONFIG_TWO, 8'h80, 0);
        xfer(0, `IDX_CONFIG_ONE, 0, 34'h88);
        xfer(0, `IDX_PERIOD_LOW, 0, 0);
        xfer(1, `IDX_CAPT_RISE_LOW, 8'hff, 0);
        xfer(0, `IDX_CAPT_RISE_LOW, 0, 0);
        idle(4);
        conclude();
    end
endmodule : timer_compare_capture_bench
bind timer_compare_capture timer_compare_capture_properties u_timer_compare_capture_properties (.*);
